// file: spm_lock_pkg.sv
// package: register map, field layout and timing constants of the store gate and lock logic
// Overview of operation
// - control register at 0x57, resets zero
// - enable arms program store for four cycles
// - enable plus command bit: special store
// - enable alone: store word into buffer
// - pointer lsb ignored for buffer word
// - enable clears on completion or timeout (here a control write in that same cycle leaves it set)
// - enable stays set during erase/write
// - only five low patterns accepted
// - lock bit one unprogrammed, zero programmed
// - only chip erase returns lock bits (here reset also reloads them all to one)
// - memory lock mode 1: no locking
// - mode 2: no programming, fuses locked
// - mode 3: no program/verify, locks locked
// - app mode 1: no restriction
// - app low zero: block stores to app
// - app high zero: block boot reads app
// - app high zero: irq off in app
// - boot mode 1: no restriction
// - boot low zero: block stores to boot
// - boot high zero: block app reads boot
// - boot high zero: irq off in boot
package spm_lock_pkg;
  // ==========================================
  // register map
  localparam logic [11:0] CTRL_ADDR = 12'h15C;
  localparam logic [11:0] LOCK_ADDR = 12'h160;
  localparam logic [11:0] STAT_ADDR = 12'h164;
  localparam logic [11:0] CFG_ADDR = 12'h168;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  // ==========================================
  // control fields
  localparam int EN_BIT = 0;
  localparam int ERS_BIT = 1;
  localparam int WRT_BIT = 2;
  localparam int LBS_BIT = 3;
  localparam int RWW_BIT = 4;
  localparam int SIG_BIT = 5;
  localparam int IE_BIT = 7;
  localparam logic [4:0] PAT_STORE = 5'h01;
  localparam logic [4:0] PAT_ERASE = 5'h03;
  localparam logic [4:0] PAT_WRITE = 5'h05;
  localparam logic [4:0] PAT_LOCK = 5'h09;
  localparam logic [4:0] PAT_RWW = 5'h11;
  localparam logic [7:0] CTRL_KEEP_MASK = 8'hE0;
  // ==========================================
  // lock byte fields
  localparam int MEM_LO = 0;
  localparam int MEM_HI = 1;
  localparam int APP_LO = 2;
  localparam int APP_HI = 3;
  localparam int BOOT_LO = 4;
  localparam int BOOT_HI = 5;
  localparam logic [7:0] LOCK_USED_MASK = 8'h3F;
  localparam logic [7:0] BOOT_LOCKS_MASK = 8'h3C;
  // ==========================================
  // timing
  localparam int ARM_WINDOW_CYC = 4;
  localparam logic [2:0] ARM_CNT_INIT = 3'(ARM_WINDOW_CYC);
  localparam logic [31:0] ERR_NONE = 32'h0000_0000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_BUSY = 4'b0100,
    ST_LOCKW = 4'b1000
  } gate_state_e;
  typedef struct packed {
    logic valid;
    logic from_boot;
    logic [15:0] zptr;
    logic [15:0] data;
  } store_req_s;
  typedef struct packed {
    logic store;
    logic erase;
    logic write;
    logic lock;
    logic rww;
    logic [14:0] word_addr;
    logic [15:0] data;
  } flash_cmd_s;
endpackage

// file: spm_lock_gate.sv
// module: store window gate, lock byte and section access protection
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
module spm_lock_gate
  import spm_lock_pkg::*;
#(
  parameter int BOOT_START_WORD = 14336
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire spm_lock_pkg::store_req_s store_req,
  output logic store_refused,
  output spm_lock_pkg::flash_cmd_s flash_cmd,
  input wire logic flash_busy,
  input wire logic chip_erase,
  input wire logic load_req,
  input wire logic load_from_boot,
  input wire logic [15:0] load_zptr,
  output logic load_block,
  input wire logic exec_in_boot,
  input wire logic vectors_in_boot,
  output logic irq_hold_off,
  input wire logic prog_write_req,
  output logic prog_write_block,
  output logic prog_verify_block,
  output logic fuse_locked,
  output logic boot_locks_locked
);
  import spm_lock_pkg::*;

  initial
  begin
    if (BOOT_START_WORD < 1 || BOOT_START_WORD > 32767)
      $error("boot start out of range");
  end

  // ==========================================
  // helpers
  function automatic logic in_boot(input logic [15:0] z);
    in_boot = ({1'b0, z[15:1]} >= 16'(BOOT_START_WORD));
  endfunction

  gate_state_e state_q;
  logic [7:0] ctrl_q;
  logic [7:0] lock_q;
  logic [2:0] arm_cnt_q;
  logic [31:0] refuse_cnt_q;
  logic [4:0] low_w;
  logic pat_ok;
  logic wr_en;
  logic busy_done;
  logic ctrl_wr;
  logic store_fire, store_block, tgt_boot;

  assign wr_en = psel && penable && pwrite;
  // flash raises busy one cycle after the command pulse
  assign busy_done = !flash_busy && !flash_cmd.erase && !flash_cmd.write;
  assign ctrl_wr = wr_en && paddr == CTRL_ADDR && pstrb[0];
  assign low_w = pwdata[4:0];
  assign pat_ok = low_w == PAT_STORE || low_w == PAT_ERASE || low_w == PAT_WRITE
    || low_w == PAT_LOCK || low_w == PAT_RWW;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == CTRL_ADDR || paddr == LOCK_ADDR
    || paddr == STAT_ADDR || paddr == CFG_ADDR);

  // ==========================================
  // protection decode
  assign tgt_boot = in_boot(store_req.zptr);
  assign store_block = tgt_boot ? !lock_q[BOOT_LO] : !lock_q[APP_LO];
  assign store_fire = store_req.valid && state_q == ST_ARMED;
  assign store_refused = store_fire && store_block && !ctrl_q[LBS_BIT] && !ctrl_q[RWW_BIT];
  assign load_block = load_req && (in_boot(load_zptr)
    ? (!load_from_boot && !lock_q[BOOT_HI])
    : (load_from_boot && !lock_q[APP_HI]));
  assign irq_hold_off = (vectors_in_boot && !exec_in_boot && !lock_q[APP_HI])
    || (!vectors_in_boot && exec_in_boot && !lock_q[BOOT_HI]);
  assign prog_write_block = prog_write_req && !lock_q[MEM_LO];
  assign prog_verify_block = !lock_q[MEM_LO] && !lock_q[MEM_HI];
  assign fuse_locked = !lock_q[MEM_LO];
  assign boot_locks_locked = !lock_q[MEM_LO] && !lock_q[MEM_HI];

  // ==========================================
  // gate state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      arm_cnt_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (ctrl_wr && pat_ok && !flash_busy)
          begin
            state_q <= ST_ARMED;
            arm_cnt_q <= ARM_CNT_INIT;
          end
        end
        ST_ARMED:
        begin
          if (store_fire)
            state_q <= ((ctrl_q[ERS_BIT] || ctrl_q[WRT_BIT]) && !store_block) ? ST_BUSY
              : ST_IDLE;
          else if (arm_cnt_q == 3'h1)
            state_q <= ST_IDLE;
          else
            arm_cnt_q <= arm_cnt_q - 3'h1;
        end
        ST_BUSY:
        begin
          if (busy_done)
            state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= CTRL_RESET;
    else if (ctrl_wr)
    begin
      ctrl_q[7:5] <= pwdata[7:5];
      if (pat_ok && state_q == ST_IDLE && !flash_busy)
        ctrl_q[4:0] <= low_w;
    end
    else if (state_q == ST_ARMED && (store_fire ? !((ctrl_q[ERS_BIT] || ctrl_q[WRT_BIT])
      && !store_block) : arm_cnt_q == 3'h1))
      ctrl_q[4:0] <= 5'h00;
    else if (state_q == ST_BUSY && busy_done)
      ctrl_q[4:0] <= 5'h00;
  end

  // ==========================================
  // lock byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lock_q <= LOCK_RESET;
    else if (chip_erase)
      lock_q <= LOCK_RESET;
    else if (store_fire && ctrl_q[LBS_BIT])
      lock_q <= lock_q & (store_req.data[7:0] | ~LOCK_USED_MASK
        | (boot_locks_locked ? BOOT_LOCKS_MASK : 8'h00));
  end

  // ==========================================
  // flash command out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flash_cmd <= '0;
    else
    begin
      flash_cmd.store <= store_fire && ctrl_q[4:0] == PAT_STORE && !store_block;
      flash_cmd.erase <= store_fire && ctrl_q[ERS_BIT] && !store_block;
      flash_cmd.write <= store_fire && ctrl_q[WRT_BIT] && !store_block;
      flash_cmd.lock <= store_fire && ctrl_q[LBS_BIT];
      flash_cmd.rww <= store_fire && ctrl_q[RWW_BIT];
      if (store_fire)
      begin
        flash_cmd.word_addr <= store_req.zptr[15:1];
        flash_cmd.data <= store_req.data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refuse_cnt_q <= ERR_NONE;
    else if (wr_en && paddr == STAT_ADDR)
      refuse_cnt_q <= ERR_NONE;
    else if (store_refused)
      refuse_cnt_q <= refuse_cnt_q + 32'h1;
  end

  // ==========================================
  // read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        CTRL_ADDR: prdata <= {24'h0, ctrl_q};
        LOCK_ADDR: prdata <= {24'h0, lock_q};
        STAT_ADDR: prdata <= refuse_cnt_q;
        CFG_ADDR: prdata <= {28'h0, state_q};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ==========================================
  // checks
  property p_arm_window;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_IDLE && ctrl_wr && pat_ok && !flash_busy) |=> state_q == ST_ARMED;
  endproperty
  a_arm_window: assert property (p_arm_window) else $error("arm failed");
  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_ARMED && !store_req.valid)[*4] |=> state_q == ST_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("window stayed open");
  property p_busy_en;
    @(posedge pclk) disable iff (!presetn)
    state_q == ST_BUSY |-> ctrl_q[EN_BIT];
  endproperty
  a_busy_en: assert property (p_busy_en) else $error("enable dropped in busy");
  property p_bad_pat;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_wr && !pat_ok && state_q == ST_IDLE) |=> $stable(ctrl_q[4:0]);
  endproperty
  a_bad_pat: assert property (p_bad_pat) else $error("bad pattern took effect");
  property p_lock_mono;
    @(posedge pclk) disable iff (!presetn)
    !$past(chip_erase) |-> ((lock_q & ~$past(lock_q)) == 8'h00);
  endproperty
  a_lock_mono: assert property (p_lock_mono) else $error("lock bit erased");
  property p_app_store;
    @(posedge pclk) disable iff (!presetn)
    (store_fire && !tgt_boot && !lock_q[APP_LO] && ctrl_q[4:0] == PAT_STORE) |=> !flash_cmd.store;
  endproperty
  a_app_store: assert property (p_app_store) else $error("app store passed");
  property p_boot_store;
    @(posedge pclk) disable iff (!presetn)
    (store_fire && tgt_boot && !lock_q[BOOT_LO]) |=> !flash_cmd.erase && !flash_cmd.write;
  endproperty
  a_boot_store: assert property (p_boot_store) else $error("boot store passed");
  property p_addr;
    @(posedge pclk) disable iff (!presetn)
    store_fire |=> flash_cmd.word_addr == $past(store_req.zptr[15:1]);
  endproperty
  a_addr: assert property (p_addr) else $error("word address wrong");
  c_store: cover property (@(posedge pclk) disable iff (!presetn) flash_cmd.store);
  c_erase: cover property (@(posedge pclk) disable iff (!presetn) state_q == ST_BUSY);
  c_refuse: cover property (@(posedge pclk) disable iff (!presetn) store_refused);
endmodule

// file: flash_model.sv
// partner model: flash array answering store gate commands
`timescale 1ns/100ps
module flash_model
  import spm_lock_pkg::*;
#(
  parameter int BUSY_CYC = 5
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire spm_lock_pkg::flash_cmd_s flash_cmd,
  output logic flash_busy,
  output spm_lock_pkg::flash_cmd_s last_cmd
);
  logic [7:0] busy_q;
  assign flash_busy = (busy_q != 8'h00);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q <= 8'h00;
      last_cmd <= '0;
    end
    else
    begin
      if (flash_cmd.store | flash_cmd.erase | flash_cmd.write | flash_cmd.rww)
        last_cmd <= flash_cmd;
      // erase and write keep the flash busy
      if (flash_cmd.erase | flash_cmd.write)
        busy_q <= 8'(BUSY_CYC);
      else if (busy_q != 8'h00)
        busy_q <= busy_q - 8'h01;
    end
  end
endmodule

// file: tb.sv
// testbench: store gate and lock protection scenarios
`timescale 1ns/100ps
module tb;
  import spm_lock_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flash_busy, refused;
  logic chip_erase, load_req, load_from_boot, load_block, exec_in_boot, vectors_in_boot;
  logic irq_hold_off, prog_write_req, prog_write_block, prog_verify_block, fuse_locked;
  logic boot_locks_locked, store_refused, slv_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [15:0] load_zptr;
  logic [4:0] pat [4] = '{5'h01, 5'h03, 5'h05, 5'h11};
  logic [4:0] kind [4] = '{5'b10000, 5'b01000, 5'b00100, 5'b00001};
  store_req_s store_req;
  flash_cmd_s flash_cmd, last_cmd;
  int err_total, n_compared;
  spm_lock_gate dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .store_req(store_req), .store_refused(store_refused),
    .flash_cmd(flash_cmd), .flash_busy(flash_busy), .chip_erase(chip_erase),
    .load_req(load_req), .load_from_boot(load_from_boot), .load_zptr(load_zptr),
    .load_block(load_block), .exec_in_boot(exec_in_boot), .vectors_in_boot(vectors_in_boot),
    .irq_hold_off(irq_hold_off), .prog_write_req(prog_write_req),
    .prog_write_block(prog_write_block), .prog_verify_block(prog_verify_block),
    .fuse_locked(fuse_locked), .boot_locks_locked(boot_locks_locked));
  flash_model fm (.pclk(pclk), .presetn(presetn), .flash_cmd(flash_cmd),
    .flash_busy(flash_busy), .last_cmd(last_cmd));
  // ==========================================
  // shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
  begin
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  end
  endtask
  task store(input logic [15:0] zp, input logic [15:0] d, input logic fb);
  begin
    store_req <= '{valid: 1'b1, from_boot: fb, zptr: zp, data: d};
    @(posedge pclk);
    refused = store_refused;
    store_req <= '0;
    repeat (2) @(posedge pclk);
  end
  endtask
  task lock_set(input logic [7:0] v);
  begin
    apb(1'b1, CTRL_ADDR, 32'h09);
    store(16'h0000, {8'h00, v}, 1'b0);
  end
  endtask
  task close_out;
  begin
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // ==========================================
  // scenarios
  task t_basic;
  begin
    rdc(CTRL_ADDR, 32'h0);
    rdc(LOCK_ADDR, 32'hFF);
    rdc(12'h100, 32'h0);
    chk(slv_err, 1'b1);
    apb(1'b1, CTRL_ADDR, 32'h07);
    rdc(CTRL_ADDR, 32'h0);
  end
  endtask
  task t_cmds;
  begin
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, CTRL_ADDR, {27'h0, pat[i]});
      store(16'h0123, 16'hA5A0 + 16'(i), 1'b0);
      chk(last_cmd[35:31], kind[i]);
      if (i == 0)
      begin
        chk(last_cmd.word_addr, 15'h0091);
        chk(last_cmd.data, 16'hA5A0);
      end
      apb(1'b0, CTRL_ADDR, 32'h0);
      chk(rdat[0], (i == 1 || i == 2));
      repeat (8) @(posedge pclk);
      rdc(CTRL_ADDR, 32'h0);
    end
  end
  endtask
  task t_window;
  begin
    apb(1'b1, CTRL_ADDR, 32'h01);
    repeat (4) @(posedge pclk);
    store(16'h0002, 16'h1111, 1'b0);
    chk(last_cmd.data, 16'hA5A3);
    rdc(CTRL_ADDR, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'h01);
    repeat (3) @(posedge pclk);
    store(16'h0002, 16'h2222, 1'b0);
    chk(last_cmd.data, 16'h2222);
    chk(last_cmd[35:31], 5'b10000);
  end
  endtask
  task t_locks;
  begin
    lock_set(8'hF3);
    rdc(LOCK_ADDR, 32'hF3);
    chk(prog_write_block, 1'b0);
    apb(1'b1, CTRL_ADDR, 32'h01);
    store(16'h0010, 16'h3333, 1'b0);
    chk(refused, 1'b1);
    rdc(STAT_ADDR, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h01);
    store(16'h7000, 16'h4444, 1'b0);
    chk(refused, 1'b0);
    load_req <= 1'b1;
    load_from_boot <= 1'b1;
    vectors_in_boot <= 1'b1;
    @(posedge pclk);
    chk({load_block, irq_hold_off}, 2'b11);
    chip_erase <= 1'b1;
    load_from_boot <= 1'b0;
    @(posedge pclk);
    chip_erase <= 1'b0;
    chk(load_block, 1'b0);
    rdc(LOCK_ADDR, 32'hFF);
    lock_set(8'hCF);
    lock_set(8'hFE);
    chk({prog_write_block, prog_verify_block, fuse_locked}, 3'b101);
    lock_set(8'hCC);
    chk({prog_verify_block, boot_locks_locked}, 2'b11);
    apb(1'b1, CTRL_ADDR, 32'h01);
    store(16'h7000, 16'h5555, 1'b0);
    chk(refused, 1'b1);
    load_zptr <= 16'h7000;
    vectors_in_boot <= 1'b0;
    exec_in_boot <= 1'b1;
    @(posedge pclk);
    chk({load_block, irq_hold_off}, 2'b11);
    lock_set(8'hC0);
    rdc(LOCK_ADDR, 32'hCC);
  end
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, chip_erase, load_req, load_from_boot} = '0;
    {exec_in_boot, vectors_in_boot} = '0;
    prog_write_req = 1'b1;
    {paddr, pwdata, load_zptr} = '0;
    load_zptr = 16'h0010;
    pstrb = 4'hF;
    store_req = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_basic;
    t_cmds;
    t_window;
    t_locks;
    close_out;
  end
  initial
  begin
    repeat (3000) @(posedge pclk);
    err_total++;
    close_out;
  end
endmodule
